// >>> common/usbg_pkg.sv
/*
  package for the global configuration and reset block of a full-speed
  usb on-the-go controller: register map, fields, reset values, timing.
  assumes an apb slave on pclk at 250 MHz and a sampled phy clock.
*/
// Operation
// R1: force device bit makes controller a device regardless of connector id.
// R2: force host bit makes controller a host regardless of connector id.
// R3: software waits at least 25 ms after setting a forced role.
// R4: four-bit turnaround field in phy clocks, resets to 5; 5 or 9 typical.
// R5: recommended turnaround values assume bus clock of 30 MHz or more.
// R6: calibration field adds its phy clocks, quarter bit each, to timeout.
// R7: base full-speed inter-packet timeout lies in 16 to 18 bit times.
// R8: corrupt transmit packet bit is debug only; software never sets it.
// R9: read-only bus master idle bit, resets to 1, shows master idle.
// R10: five-bit select picks one transmit fifo, or all with code 10000.
// R11: software keeps fifo select unchanged while transmit flush pends.
// R12: transmit flush bit flushes selection, self-clears within 8 slow clocks.
// R13: software checks fifo unused before transmit flush, waits for clear.
// R14: receive flush bit empties receive fifo, self-clears within 8 clocks.
// R15: frame counter reset bit zeroes frame number, self-clears shortly.
// R16: protocol engine reset bit idles engine machines, self-clears when done.
// R17: controller reset clears registers, flags, machines and all fifos.
// R18: usb transactions stop at once; bus master stops after current beat.
// R19: controller reset settable anytime, clears after state-dependent delay.
// R20: after reset clears, software waits 3 phy clocks and master idle.
// R21: fifo status flags are read-only, cleared by fifo access.
// R22: software clears interrupt status before enabling interrupts.
// R23: writing 0 to self-clearing bits does nothing, cancels nothing.
package usbg_pkg;

  localparam logic [11:0] OFS_USB_CONFIG   = 12'h00C;
  localparam logic [11:0] OFS_RESET_CTRL   = 12'h010;
  localparam logic [11:0] OFS_FIFO_STATUS  = 12'h014;

  // usb_config_global fields
  localparam int CFG_CORRUPT_TX   = 31;
  localparam int CFG_FORCE_DEV    = 30;
  localparam int CFG_FORCE_HOST   = 29;
  localparam int CFG_TRDT_LSB     = 10;
  localparam int CFG_TRDT_MSB     = 13;
  localparam int CFG_TOUT_LSB     = 0;
  localparam int CFG_TOUT_MSB     = 2;
  localparam int CFG_RSVD_LSB     = 3;
  localparam int CFG_RSVD_MSB     = 9;
  localparam logic [3:0] TRDT_RESET = 4'h5;
  localparam logic [6:0] CFG_RSVD_RESET = 7'h08;

  // core_reset_control fields
  localparam int RST_MASTER_IDLE  = 31;
  localparam int RST_SEL_LSB      = 6;
  localparam int RST_SEL_MSB      = 10;
  localparam int RST_TX_FLUSH     = 5;
  localparam int RST_RX_FLUSH     = 4;
  localparam int RST_FRAME_CNT    = 2;
  localparam int RST_PE_RESET     = 1;
  localparam int RST_CTRL_RESET   = 0;
  localparam logic [4:0] SEL_ALL_FIFOS = 5'h10;

  // fifo status flags
  localparam int FST_TX_EMPTY     = 0;
  localparam int FST_RX_AVAIL     = 1;

  // timing, counted in sampled phy clock edges (phy clock is the slower); timeout base in bit times
  localparam logic [3:0] FLUSH_CLKS     = 4'h8;
  localparam logic [3:0] FRAME_CLR_CLKS = 4'h3;
  localparam logic [3:0] PE_RESET_CLKS  = 4'h4;
  localparam logic [3:0] CORE_RST_CLKS  = 4'h6;
  localparam logic [6:0] BASE_TOUT_BITS = 7'h10;
  localparam logic [2:0] PHY_PER_BIT    = 3'h4;

  typedef struct packed {
    logic       tx_flush;
    logic [4:0] tx_select;
    logic       rx_flush;
  } usbg_flush_t;

  typedef enum logic [1:0] {
    CR_IDLE,
    CR_DRAIN,
    CR_HOLD
  } usbg_core_rst_t;

endpackage : usbg_pkg

// >>> src/usbg_sync.sv
/*
  two flip-flop synchroniser with rising edge detect on the synced level.
  assumes inputs asynchronous to clk; reset asynchronous, active low.
*/
`timescale 1ns/10ps
module usbg_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign rise_out = sync_q & ~prev_q;

endmodule : usbg_sync

// >>> src/usbg_global_ctrl.sv
/*
  global configuration and reset/flush control of the usb controller,
  reached over apb. assumes phy_clk and conn_id arrive asynchronously and
  are sampled on pclk; fifo and engine logic obey the request levels.
*/
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module usbg_global_ctrl
  import usbg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phy_clk,
  input  wire logic        conn_id,
  input  wire logic        bus_master_idle,
  input  wire logic        tx_fifo_empty_evt,
  input  wire logic        rx_fifo_avail_evt,
  input  wire logic        tx_fifo_access,
  input  wire logic        rx_fifo_access,
  output logic             host_role,
  output logic             corrupt_tx,
  output logic [3:0]       turnaround_clocks,
  output logic [6:0]       timeout_phy_clocks,
  output usbg_flush_t      flush_req,
  output logic             frame_counter_reset,
  output logic             protocol_engine_soft_reset,
  output logic             controller_soft_reset,
  output logic             usb_abort,
  output logic             bus_master_stop
);

  ////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == OFS_USB_CONFIG) || (a == OFS_RESET_CTRL) ||
             (a == OFS_FIFO_STATUS);
  endfunction : mapped

  logic        ready_q;
  logic        access;
  logic        wr_en;
  logic        wr_cfg;
  logic        wr_rst;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  assign access = psel & penable;
  assign wr_en  = access & ready_q & pwrite & mapped(paddr);
  assign wr_cfg = wr_en & (paddr == OFS_USB_CONFIG);
  assign wr_rst = wr_en & (paddr == OFS_RESET_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // phy clock and connector id sampling
  logic [1:0] sync_lvl;
  logic [1:0] sync_rise;
  logic       phy_edge;
  logic       id_b_device;

  usbg_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({conn_id, phy_clk}),
    .sync_out (sync_lvl),
    .rise_out (sync_rise)
  );

  assign phy_edge    = sync_rise[0];
  assign id_b_device = sync_lvl[1];

  ////////////////////////////////////////////////////////////////////////
  // controller soft reset sequencer
  usbg_core_rst_t cr_state_q;
  logic [3:0]     cr_cnt_q;
  logic           core_clear;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr_state_q <= CR_IDLE;
      cr_cnt_q   <= '0;
    end else begin
      case (cr_state_q)
        CR_IDLE: begin
          if (wr_rst && pwdata[RST_CTRL_RESET]) begin // see R19 see R23
            cr_state_q <= CR_DRAIN;
          end
        end
        CR_DRAIN: begin
          if (bus_master_idle) begin // see R18
            cr_state_q <= CR_HOLD;
            cr_cnt_q   <= CORE_RST_CLKS;
          end
        end
        CR_HOLD: begin
          if (phy_edge) begin
            if (cr_cnt_q == 4'h1) begin
              cr_state_q <= CR_IDLE;
            end
            cr_cnt_q <= cr_cnt_q - 4'h1;
          end
        end
        default: begin
          cr_state_q <= CR_IDLE;
        end
      endcase
    end
  end

  // one-cycle wipe of registers and flags when the reset completes
  assign core_clear = (cr_state_q == CR_HOLD) && phy_edge &&
                      (cr_cnt_q == 4'h1);

  assign controller_soft_reset = (cr_state_q != CR_IDLE); // see R17
  assign usb_abort             = (cr_state_q != CR_IDLE); // see R18
  assign bus_master_stop       = (cr_state_q == CR_DRAIN); // see R18

  ////////////////////////////////////////////////////////////////////////
  // usb_config_global
  logic       corrupt_q;
  logic       force_dev_q;
  logic       force_host_q;
  logic [3:0] trdt_q;
  logic [2:0] tout_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corrupt_q    <= 1'b0;
      force_dev_q  <= 1'b0;
      force_host_q <= 1'b0;
      trdt_q       <= TRDT_RESET;
      tout_q       <= '0;
    end else if (core_clear) begin // see R17
      corrupt_q    <= 1'b0;
      force_dev_q  <= 1'b0;
      force_host_q <= 1'b0;
      trdt_q       <= TRDT_RESET;
      tout_q       <= '0;
    end else if (wr_cfg) begin
      corrupt_q    <= pwdata[CFG_CORRUPT_TX]; // see R8
      force_dev_q  <= pwdata[CFG_FORCE_DEV];
      force_host_q <= pwdata[CFG_FORCE_HOST];
      trdt_q       <= pwdata[CFG_TRDT_MSB:CFG_TRDT_LSB]; // see R4 see R5
      tout_q       <= pwdata[CFG_TOUT_MSB:CFG_TOUT_LSB];
    end
  end

  // id low means a-device, which takes the host role
  always_comb begin
    if (force_dev_q) begin
      host_role = 1'b0; // see R1
    end else if (force_host_q) begin
      host_role = 1'b1; // see R2
    end else begin
      host_role = ~id_b_device;
    end
  end

  assign corrupt_tx        = corrupt_q;
  assign turnaround_clocks = trdt_q; // see R4
  // base of 16 bit times, four phy clocks each, plus calibration
  assign timeout_phy_clocks = 7'(BASE_TOUT_BITS * PHY_PER_BIT) // see R7
                              + 7'(tout_q); // see R6

  ////////////////////////////////////////////////////////////////////////
  // transmit / receive flush
  logic       tx_flush_q;
  logic       rx_flush_q;
  logic [4:0] tx_sel_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] rx_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sel_q <= '0;
    end else if (core_clear) begin
      tx_sel_q <= '0;
    end else if (wr_rst) begin
      tx_sel_q <= pwdata[RST_SEL_MSB:RST_SEL_LSB]; // see R10 see R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_flush_q <= 1'b0;
      tx_cnt_q   <= '0;
    end else if (!tx_flush_q) begin
      if (wr_rst && pwdata[RST_TX_FLUSH]) begin // see R12 see R13 see R23
        tx_flush_q <= 1'b1;
        tx_cnt_q   <= FLUSH_CLKS;
      end
    end else if (phy_edge) begin
      if (tx_cnt_q == 4'h1) begin
        tx_flush_q <= 1'b0; // see R12
      end
      tx_cnt_q <= tx_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flush_q <= 1'b0;
      rx_cnt_q   <= '0;
    end else if (!rx_flush_q) begin
      if (wr_rst && pwdata[RST_RX_FLUSH]) begin // see R14 see R23
        rx_flush_q <= 1'b1;
        rx_cnt_q   <= FLUSH_CLKS;
      end
    end else if (phy_edge) begin
      if (rx_cnt_q == 4'h1) begin
        rx_flush_q <= 1'b0; // see R14
      end
      rx_cnt_q <= rx_cnt_q - 4'h1;
    end
  end

  // soft reset empties every fifo as well
  always_comb begin
    flush_req.tx_flush  = tx_flush_q | controller_soft_reset; // see R17
    flush_req.tx_select = controller_soft_reset ? SEL_ALL_FIFOS : tx_sel_q;
    flush_req.rx_flush  = rx_flush_q | controller_soft_reset;
  end

  ////////////////////////////////////////////////////////////////////////
  // frame counter and protocol engine resets
  logic       frame_q;
  logic [3:0] frame_cnt_q;
  logic       pe_q;
  logic [3:0] pe_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q     <= 1'b0;
      frame_cnt_q <= '0;
    end else if (!frame_q) begin
      if (wr_rst && pwdata[RST_FRAME_CNT]) begin // see R15 see R23
        frame_q     <= 1'b1;
        frame_cnt_q <= FRAME_CLR_CLKS;
      end
    end else if (phy_edge) begin
      if (frame_cnt_q == 4'h1) begin
        frame_q <= 1'b0; // see R15
      end
      frame_cnt_q <= frame_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_q     <= 1'b0;
      pe_cnt_q <= '0;
    end else if (!pe_q) begin
      if (wr_rst && pwdata[RST_PE_RESET]) begin // see R16 see R23
        pe_q     <= 1'b1;
        pe_cnt_q <= PE_RESET_CLKS;
      end
    end else if (phy_edge) begin
      if (pe_cnt_q == 4'h1) begin
        pe_q <= 1'b0; // see R16
      end
      pe_cnt_q <= pe_cnt_q - 4'h1;
    end
  end

  assign frame_counter_reset        = frame_q | controller_soft_reset;
  assign protocol_engine_soft_reset = pe_q | controller_soft_reset;

  ////////////////////////////////////////////////////////////////////////
  // fifo status flags, set wins over clear
  logic tx_empty_q;
  logic rx_avail_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_q <= 1'b0;
    end else if (tx_fifo_empty_evt) begin
      tx_empty_q <= 1'b1;
    end else if (tx_fifo_access || core_clear) begin // see R21 see R17
      tx_empty_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_avail_q <= 1'b0;
    end else if (rx_fifo_avail_evt) begin
      rx_avail_q <= 1'b1;
    end else if (rx_fifo_access || core_clear) begin // see R21 see R17
      rx_avail_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and apb answer
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (paddr)
      OFS_USB_CONFIG: begin
        rd_word[CFG_CORRUPT_TX]            = corrupt_q;
        rd_word[CFG_FORCE_DEV]             = force_dev_q;
        rd_word[CFG_FORCE_HOST]            = force_host_q;
        rd_word[CFG_TRDT_MSB:CFG_TRDT_LSB] = trdt_q;
        rd_word[CFG_RSVD_MSB:CFG_RSVD_LSB] = CFG_RSVD_RESET;
        rd_word[CFG_TOUT_MSB:CFG_TOUT_LSB] = tout_q;
      end
      OFS_RESET_CTRL: begin
        rd_word[RST_MASTER_IDLE]         = bus_master_idle; // see R9
        rd_word[RST_SEL_MSB:RST_SEL_LSB] = tx_sel_q;
        rd_word[RST_TX_FLUSH]            = tx_flush_q;
        rd_word[RST_RX_FLUSH]            = rx_flush_q;
        rd_word[RST_FRAME_CNT]           = frame_q;
        rd_word[RST_PE_RESET]            = pe_q;
        rd_word[RST_CTRL_RESET]          = controller_soft_reset;
      end
      OFS_FIFO_STATUS: begin
        rd_word[FST_TX_EMPTY] = tx_empty_q; // see R21
        rd_word[FST_RX_AVAIL] = rx_avail_q;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q   <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      ready_q <= access & ~ready_q;
      if (access && !ready_q) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr_q <= ~mapped(paddr);
      end
    end
  end

  assign pready  = ready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & ready_q;

endmodule : usbg_global_ctrl

// >>> bench/usbg_phy_model.sv
/*
  far side: free-running phy clock and a bus master that stays busy
  from a request until told to stop, then ends its current beat.
  assumes pclk and the busy request come from the bench.
*/
`timescale 1ns/10ps
module usbg_phy_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic busy_req,
  input  wire logic bus_master_stop,
  output logic      phy_clk,
  output logic      bus_master_idle
);
  logic       busy_q;
  logic [1:0] beat_q;
  initial begin
    phy_clk = 1'b0;
    #3;
    forever #16 phy_clk = ~phy_clk;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) beat_q <= 2'h0;
    else beat_q <= beat_q + 2'h1;
  // stop only at the end of a beat
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) busy_q <= 1'b0;
    else if (busy_req) busy_q <= 1'b1;
    else if (bus_master_stop && beat_q == 2'h3) busy_q <= 1'b0;
  assign bus_master_idle = !busy_q;
endmodule : usbg_phy_model

// >>> bench/usbg_global_ctrl_monitor.sv
/*
  checker of the global config and reset block, bound to its top.
  assumes a phy clock near 32 ns and a 4 ns pclk.
*/
`timescale 1ns/10ps
module usbg_global_ctrl_monitor
  import usbg_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        bus_master_idle,
  input wire logic        host_role,
  input wire logic [3:0]  turnaround_clocks,
  input wire logic [6:0]  timeout_phy_clocks,
  input wire usbg_flush_t flush_req,
  input wire logic        frame_counter_reset,
  input wire logic        protocol_engine_soft_reset,
  input wire logic        controller_soft_reset,
  input wire logic        usb_abort
);
  logic [31:0] cfg_q;
  logic        wr_done;
  logic        csr;
  assign wr_done = psel & penable & pready & pwrite;
  assign csr = controller_soft_reset;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the config word
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg_q <= 32'h0000_1440;
    else if (csr) cfg_q <= 32'h0000_1440;
    else if (wr_done && paddr == OFS_USB_CONFIG) cfg_q <= pwdata;
  ////////////////////////////////////////////////////////////////////
  a_role_device:
    assert property (!csr && cfg_q[30] |-> !host_role)
    else $error("forced device role lost");
  a_role_host:
    assert property (!csr && cfg_q[30:29] == 2'h1 |-> host_role)
    else $error("forced host role lost");
  a_turn_field:
    assert property (!csr |-> turnaround_clocks == cfg_q[13:10])
    else $error("turnaround field wrong");
  a_tout_sum:
    assert property (!csr |-> timeout_phy_clocks == 7'h40 + cfg_q[2:0])
    else $error("timeout sum wrong");
  a_tx_self_clear:
    assert property ($rose(flush_req.tx_flush) && !csr |->
      ##48 flush_req.tx_flush ##[1:24] !flush_req.tx_flush)
    else $error("tx flush clear time wrong");
  a_rx_self_clear:
    assert property ($rose(flush_req.rx_flush) && !csr |->
      ##48 flush_req.rx_flush ##[1:24] !flush_req.rx_flush)
    else $error("rx flush clear time wrong");
  a_frame_clear:
    assert property ($rose(frame_counter_reset) && !csr |->
      ##16 frame_counter_reset ##[1:16] !frame_counter_reset)
    else $error("frame reset clear time wrong");
  a_engine_clear:
    assert property ($rose(protocol_engine_soft_reset) && !csr |->
      ##24 protocol_engine_soft_reset ##[1:16] !protocol_engine_soft_reset)
    else $error("engine reset clear time wrong");
  a_reset_all:
    assert property (csr |-> flush_req == {1'b1, SEL_ALL_FIFOS, 1'b1}
      && frame_counter_reset && protocol_engine_soft_reset)
    else $error("controller reset misses a unit");
  a_usb_stop:
    assert property ($rose(csr) |-> usb_abort [*8])
    else $error("usb abort not held");
  a_wait_master:
    assert property (csr && !bus_master_idle |=> csr)
    else $error("reset ended with master busy");
  c_ctrl_reset: cover property ($rose(csr));
  c_tx_flush: cover property ($rose(flush_req.tx_flush) && !csr);
  c_forced: cover property (!csr && cfg_q[30:29] == 2'h3);
endmodule : usbg_global_ctrl_monitor
bind usbg_global_ctrl usbg_global_ctrl_monitor usbg_global_ctrl_monitor_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .bus_master_idle, .host_role, .turnaround_clocks, .timeout_phy_clocks,
  .flush_req, .frame_counter_reset, .protocol_engine_soft_reset,
  .controller_soft_reset, .usb_abort
);

// >>> bench/tb_usbg_global_ctrl.sv
/*
  bench for the global config and reset block: random config words,
  flush codes, controller reset, fifo flags, unmapped access.
  assumes usbg_phy_model on the far side and a 4 ns pclk.
*/
`timescale 1ns/10ps
module tb_usbg_global_ctrl
  import usbg_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        phy_clk, conn_id, bus_master_idle, busy_req, host_role;
  logic        corrupt_tx, frame_counter_reset, usb_abort;
  logic        protocol_engine_soft_reset, controller_soft_reset;
  logic        bus_master_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  fev, turnaround_clocks;
  logic [6:0]  timeout_phy_clocks;
  usbg_flush_t flush_req;
  int          num_errors, comparisons;

  usbg_global_ctrl usbg_global_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .phy_clk, .conn_id, .bus_master_idle,
    .tx_fifo_empty_evt(fev[0]), .rx_fifo_avail_evt(fev[1]),
    .tx_fifo_access(fev[2]), .rx_fifo_access(fev[3]), .host_role,
    .corrupt_tx, .turnaround_clocks, .timeout_phy_clocks, .flush_req,
    .frame_counter_reset, .protocol_engine_soft_reset,
    .controller_soft_reset, .usb_abort, .bus_master_stop
  );
  usbg_phy_model usbg_phy_model_inst (
    .pclk, .presetn, .busy_req, .bus_master_stop, .phy_clk, .bus_master_idle
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] ex);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(nm, ex, q);
  endtask : rd_chk
  task automatic ev(input logic [3:0] v);
    fev <= v;
    @(posedge pclk);
    fev <= 4'h0;
  endtask : ev
  function automatic logic busy_bit(input int b);
    case (b)
      5: return flush_req.tx_flush;
      4: return flush_req.rx_flush;
      2: return frame_counter_reset;
      1: return protocol_engine_soft_reset;
      default: return controller_soft_reset;
    endcase
  endfunction : busy_bit
  task automatic wait_clear(input int b, input int lim, output int n);
    n = 0;
    while (busy_bit(b) !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      close_out();
    end
  endtask : wait_clear
  function automatic logic [31:0] exp_cfg(input logic [31:0] d);
    return (d & 32'hE000_3C07) | 32'h0000_0040;
  endfunction : exp_cfg
  function automatic logic exp_role(input logic [31:0] d, input logic id);
    return d[30] ? 1'b0 : (d[29] ? 1'b1 : !id);
  endfunction : exp_role
  function automatic int exp_edges(input int b);
    return (b > 3) ? 8 : ((b == 2) ? 3 : 4);
  endfunction : exp_edges
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
    logic [4:0]  sel;
    int          b;
    int          n;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    conn_id = 1'b0;
    busy_req = 1'b0;
    fev = 4'h0;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(24));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ev(4'hC);
    rd_chk("cfg reset", OFS_USB_CONFIG, 32'h0000_1440);
    rd_chk("rst reset", OFS_RESET_CTRL, 32'h8000_0000);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      if (i < 3) d[30:29] = 2'(i + 1);
      d[31] = 1'b0;
      conn_id <= 1'($urandom());
      xfer(1'b1, OFS_USB_CONFIG, d, q, e);
      repeat (4) @(posedge pclk);
      rd_chk("cfg word", OFS_USB_CONFIG, exp_cfg(d));
      chk("role", 32'(exp_role(d, conn_id)), 32'(host_role));
      chk("turn", 32'(d[13:10]), 32'(turnaround_clocks));
      chk("tout", 32'h40 + d[2:0], 32'(timeout_phy_clocks));
      chk("corrupt", 32'(d[31]), 32'(corrupt_tx));
    end
    $display("test config words done");
    xfer(1'b0, 12'h020, 32'h0, q, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    $display("test unmapped done");
    for (int i = 0; i < 8; i++) begin
      b = (i < 5) ? 5 : ((i == 5) ? 4 : 8 - i);
      sel = (i == 3) ? 5'h10 : ((i == 2) ? 5'h0F : 5'(i));
      if (i > 3) sel = 5'($urandom_range(2, 14));
      d = 32'(sel) << 6;
      xfer(1'b1, OFS_RESET_CTRL, d | (32'h1 << b), q, e);
      chk("flush on", 32'h1, 32'(busy_bit(b)));
      chk("select", 32'(sel), 32'(flush_req.tx_select));
      xfer(1'b1, OFS_RESET_CTRL, d, q, e);
      chk("zero write", 32'h1, 32'(busy_bit(b)));
      wait_clear(b, 100, n);
      n = n + 5;
      chk("clear time", 32'h1, 32'(n <= exp_edges(b) * 8 + 12 &&
          n >= (exp_edges(b) - 1) * 8));
      rd_chk("rst field", OFS_RESET_CTRL, 32'h8000_0000 | d);
    end
    $display("test flush codes done");
    xfer(1'b1, OFS_USB_CONFIG, 32'h4000_3807, q, e);
    busy_req <= 1'b1;
    @(posedge pclk);
    busy_req <= 1'b0;
    rd_chk("idle live", OFS_RESET_CTRL, d);
    xfer(1'b1, OFS_RESET_CTRL, 32'h1, q, e);
    chk("abort", 32'h1, 32'(usb_abort & controller_soft_reset));
    chk("all fifos", 32'(SEL_ALL_FIFOS), 32'(flush_req.tx_select));
    wait_clear(0, 300, n);
    chk("reset time", 32'h1, 32'(n > 30 && n < 300));
    repeat (24) @(posedge pclk);
    rd_chk("cfg after", OFS_USB_CONFIG, 32'h0000_1440);
    rd_chk("rst after", OFS_RESET_CTRL, 32'h8000_0000);
    $display("test controller reset done");
    ev(4'h3);
    rd_chk("flags set", OFS_FIFO_STATUS, 32'h3);
    xfer(1'b1, OFS_FIFO_STATUS, 32'h0, q, e);
    rd_chk("flags ro", OFS_FIFO_STATUS, 32'h3);
    ev(4'h5);
    rd_chk("set wins", OFS_FIFO_STATUS, 32'h3);
    ev(4'hC);
    rd_chk("flags clear", OFS_FIFO_STATUS, 32'h0);
    $display("test fifo flags done");
    close_out();
  end
endmodule : tb_usbg_global_ctrl
